// ---- hw/three_wire_rx.sv ----
// Device end: receives frames and updates the configuration registers.
`timescale 1ns/1ps
module three_wire_rx #(
	parameter int NUM_ADDR = three_wire_pkg::NUM_ADDR
) (
	input  wire logic                                 ref_clk,
	input  wire logic                                 rst_n,
	three_wire_if.dev                                 link,
	output logic [NUM_ADDR-1:0][7:0]                  cfg8_q,
	output logic [NUM_ADDR-1:0][15:0]                 cfg16_q,
	output logic [NUM_ADDR-1:0][23:0]                 cfg24_q,
	output logic [three_wire_pkg::IF_GAIN_W-1:0]      if_gain_q,
	output logic                                      wr_stb_q,
	output three_wire_pkg::frame_len_t                wr_len_q,
	output logic [three_wire_pkg::ADDR_W-1:0]         wr_addr_q,
	output logic                                      drop_stb_q
);
	// ------------------------------------------------------------
	// Local names
	// ------------------------------------------------------------
	// Short aliases for the word, count and address widths.
	localparam int W  = three_wire_pkg::WORD_W;
	localparam int CW = three_wire_pkg::CNT_W;
	localparam int AW = three_wire_pkg::ADDR_W;

	// Link-domain state.
	// Shift word, count and toggle are cleared by the reference reset and clocked by the link clock; armed_q is set by enable.
	logic          link_clr_q;
	logic          armed_q;
	logic [W-1:0]  shift_q;
	logic [CW-1:0] cnt_q;
	logic          tog_q;

	// Reference-domain state.
	// Clocked by ref_clk; the synchronous reset sets en_s and en_s_q high and seen_q low.
	logic          en_s;
	logic          en_s_q;
	logic          seen_q;

	// ------------------------------------------------------------
	// Link clock domain
	// ------------------------------------------------------------
	// This logic runs only while the host clocks the link, so it may stop
	// for long stretches. It therefore holds nothing that needs a steady
	// clock: the shift word, the edge count and the frame toggle simply
	// freeze between frames and wait for the reference side to read them.
	// The clear comes from the reference domain and acts asynchronously,
	// because no link clock edge need arrive during reset.
	// Held high while ref_clk is in reset, clearing the link-side shift word, count and toggle.
	always_ff @(posedge ref_clk) begin
		link_clr_q <= !rst_n;
	end

	// Armed while enable is high, so the first edge of a frame restarts the shift.
	// Setting it from the enable level itself, not from a clock edge, means a
	// frame restarts cleanly even when the clock stayed still between frames.
	always_ff @(posedge link.bus_clk or posedge link.en_n) begin
		if (link.en_n) begin
			armed_q <= 1'b1;
		end else begin
			armed_q <= 1'b0;
		end
	end

	// Shifts one bit per rising edge while enable is low and counts the edges.
	// The counter saturates so an overlong frame never aliases onto a valid length.
	// The frame toggle flips on the first edge, marking that a new word exists.
	// Bits move towards the top, so the first bit sent ends as the frame's MSB.
	always_ff @(posedge link.bus_clk or posedge link_clr_q) begin
		if (link_clr_q) begin
			shift_q <= three_wire_pkg::CFG_RESET;
			cnt_q   <= '0;
			tog_q   <= 1'b0;
		end else if (!link.en_n) begin
			if (armed_q) begin
				shift_q <= {{(W-1){1'b0}}, link.sdata};
				cnt_q   <= three_wire_pkg::CNT_ONE;
				tog_q   <= !tog_q;
			end else begin
				shift_q <= {shift_q[W-2:0], link.sdata};
				cnt_q   <= (cnt_q == three_wire_pkg::CNT_MAX) ?
				           cnt_q : cnt_q + three_wire_pkg::CNT_ONE;
			end
		end
	end

	// ------------------------------------------------------------
	// Frame end detection in the reference domain
	// ------------------------------------------------------------
	// Enable is the only link wire that the reference side watches live,
	// so it alone goes through the two-flop synchroniser. Its reset level
	// is high, the idle level of the pin, so no false frame end follows reset.
	level_sync #(
		.RST_VAL (1'b1)
	) u_en_sync (
		.clk   (ref_clk),
		.rst_n (rst_n),
		.d     (link.en_n),
		.q     (en_s)
	);

	// Shift word, count and toggle are static once enable is high,
	// so they are read directly after the synchronised rising edge.
	// The synchroniser adds two reference cycles of delay, which is far
	// shorter than the gap the host leaves before its next frame; the
	// next first bit is therefore never taken before this one is consumed.
	// A frame with no clock edge leaves the toggle as it was and is ignored.
	wire           frame_end = en_s && !en_s_q;
	wire           new_frame = frame_end && (tog_q != seen_q);
	wire           is8       = cnt_q == three_wire_pkg::LEN8_BITS;
	wire           is16      = cnt_q == three_wire_pkg::LEN16_BITS;
	wire           is24      = cnt_q == three_wire_pkg::LEN24_BITS;
	wire           len_ok    = is8 || is16 || is24;
	wire           commit    = new_frame && len_ok;
	wire           drop      = new_frame && !len_ok;
	wire [AW-1:0]  addr      = shift_q[three_wire_pkg::ADDR_LSB +: AW];
	wire           gain_hit  = commit && is16 && (addr == three_wire_pkg::IF_GAIN_ADDR);

	// Length code reported with each accepted write.
	// Only the three legal lengths reach it, since it is latched on commit alone.
	three_wire_pkg::frame_len_t len_code;
	assign len_code = is24 ? three_wire_pkg::LEN_24 :
	                  is16 ? three_wire_pkg::LEN_16 : three_wire_pkg::LEN_8;

	// Tracks the edge history of enable and the last frame consumed.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			en_s_q <= 1'b1;
			seen_q <= 1'b0;
		end else begin
			en_s_q <= en_s;
			if (frame_end) begin
				seen_q <= tog_q;
			end
		end
	end

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	// Next values of the three register banks.
	logic [NUM_ADDR-1:0][7:0]  cfg8_d;
	logic [NUM_ADDR-1:0][15:0] cfg16_d;
	logic [NUM_ADDR-1:0][23:0] cfg24_d;

	// Each entry takes the whole word when its length and address both match.
	// The address bits sit at the same place for every length.
	for (genvar a = 0; a < NUM_ADDR; a++) begin : g_entry
		wire hit = addr == AW'(a);
		assign cfg8_d[a]  = (commit && is8 && hit)  ? shift_q[7:0]  : cfg8_q[a];
		assign cfg16_d[a] = (commit && is16 && hit) ? shift_q[15:0] : cfg16_q[a];
		assign cfg24_d[a] = (commit && is24 && hit) ? shift_q[23:0] : cfg24_q[a];
	end

	// Holds the register contents and the one-cycle write reports.
	// Every bank loads its next value each cycle, so an entry that is not
	// hit simply keeps what it had. The length and address of the last
	// accepted write stay until the next one; a dropped frame changes neither.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cfg8_q     <= {NUM_ADDR{three_wire_pkg::CFG_RESET[7:0]}};
			cfg16_q    <= {NUM_ADDR{three_wire_pkg::CFG_RESET[15:0]}};
			cfg24_q    <= {NUM_ADDR{three_wire_pkg::CFG_RESET}};
			wr_stb_q   <= 1'b0;
			wr_len_q   <= three_wire_pkg::LEN_8;
			wr_addr_q  <= '0;
			drop_stb_q <= 1'b0;
		end else begin
			cfg8_q     <= cfg8_d;
			cfg16_q    <= cfg16_d;
			cfg24_q    <= cfg24_d;
			wr_stb_q   <= commit;
			drop_stb_q <= drop;
			if (commit) begin
				wr_len_q  <= len_code;
				wr_addr_q <= addr;
			end
		end
	end

	// ------------------------------------------------------------
	// IF amplifier gain
	// ------------------------------------------------------------
	// Gain code as it sits in the received word.
	wire [three_wire_pkg::IF_GAIN_W-1:0] gain_code =
		shift_q[three_wire_pkg::IF_GAIN_LSB +: three_wire_pkg::IF_GAIN_W];

	// The 4-bit code is passed on as written; each step is 2 dB from 12 dB.
	// No mapping of codes to steps is applied here, so whatever the host
	// writes reaches the gain stage unchanged.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			if_gain_q <= three_wire_pkg::IF_GAIN_RESET;
		end else if (gain_hit) begin
			if_gain_q <= gain_code;
		end
	end
endmodule : three_wire_rx

// ---- hw/three_wire_pkg.sv ----
// Shared constants and types for the three-wire configuration link.
package three_wire_pkg;

	// ------------------------------------------------------------
	// Timing of the link
	// ------------------------------------------------------------
	localparam int REF_CLK_NS        = 10;    // Period of ref_clk.
	localparam int BUS_CLK_PERIOD_NS = 1000;  // Shortest bus clock period.
	localparam int BUS_CLK_HL_NS     = 250;   // Shortest bus clock high or low time.
	localparam int SETUP_NS          = 100;   // Shortest setup before a rising edge.
	localparam int EN_HOLD_NS        = 250;   // Shortest hold of enable after the last edge.

	localparam int HALF_NS     = (BUS_CLK_PERIOD_NS / 2 > BUS_CLK_HL_NS) ?
	                             BUS_CLK_PERIOD_NS / 2 : BUS_CLK_HL_NS;
	localparam int HALF_CYC    = (HALF_NS + REF_CLK_NS - 1) / REF_CLK_NS;
	localparam int SETUP_CYC   = (SETUP_NS + REF_CLK_NS - 1) / REF_CLK_NS;
	localparam int EN_HOLD_CYC = (EN_HOLD_NS + REF_CLK_NS - 1) / REF_CLK_NS;
	localparam int LOW_CYC     = (HALF_CYC > SETUP_CYC) ? HALF_CYC : SETUP_CYC;
	localparam int GAP_CYC     = HALF_CYC;
	localparam int TMR_W       = 8;

	// ------------------------------------------------------------
	// Frame layout
	// ------------------------------------------------------------
	localparam int WORD_W   = 24;
	localparam int CNT_W    = 5;
	localparam int NUM_ADDR = 4;
	localparam int ADDR_W   = 2;
	localparam int ADDR_LSB = 6;

	localparam logic [CNT_W-1:0]  LEN8_BITS  = 5'h08;
	localparam logic [CNT_W-1:0]  LEN16_BITS = 5'h10;
	localparam logic [CNT_W-1:0]  LEN24_BITS = 5'h18;
	localparam logic [CNT_W-1:0]  CNT_MAX    = 5'h1F;
	localparam logic [CNT_W-1:0]  CNT_ONE    = 5'h01;
	localparam logic [WORD_W-1:0] CFG_RESET  = 24'h000000;

	// Gain field of the IF amplifier, held in one 16-bit register.
	localparam logic [ADDR_W-1:0] IF_GAIN_ADDR  = 2'h0;
	localparam int                IF_GAIN_LSB   = 6;
	localparam int                IF_GAIN_W     = 4;
	localparam logic [3:0]        IF_GAIN_RESET = 4'h0;

	typedef enum logic [1:0] {
		LEN_8,
		LEN_16,
		LEN_24
	} frame_len_t;

endpackage : three_wire_pkg

// ---- hw/three_wire_if.sv ----
// Interface carrying the enable, clock and data wires of the link.
`timescale 1ns/1ps
interface three_wire_if;
	logic en_n;
	logic bus_clk;
	logic sdata;

	modport host (
		output en_n,
		output bus_clk,
		output sdata
	);

	modport dev (
		input en_n,
		input bus_clk,
		input sdata
	);
endinterface : three_wire_if

// ---- hw/level_sync.sv ----
// Two-flop synchroniser for a single level.
`timescale 1ns/1ps
module level_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic d,
	output logic      q
);
	logic meta_q;

	// ------------------------------------------------------------
	// Synchroniser stages
	// ------------------------------------------------------------
	// The first stage feeds only the second stage.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : level_sync

// ---- hw/three_wire_tx.sv ----
// Host end: sends one register word per frame over the link.
`timescale 1ns/1ps
module three_wire_tx #(
	parameter int HALF_CYC    = three_wire_pkg::HALF_CYC,
	parameter int LOW_CYC     = three_wire_pkg::LOW_CYC,
	parameter int EN_HOLD_CYC = three_wire_pkg::EN_HOLD_CYC,
	parameter int GAP_CYC     = three_wire_pkg::GAP_CYC
) (
	input  wire logic                                ref_clk,
	input  wire logic                                rst_n,
	three_wire_if.host                               link,
	input  wire logic                                cmd_valid,
	input  wire three_wire_pkg::frame_len_t          cmd_len,
	input  wire logic [three_wire_pkg::WORD_W-1:0]   cmd_word,
	output logic                                     cmd_ready_q,
	output logic                                     cmd_done_q
);
	localparam int W  = three_wire_pkg::WORD_W;
	localparam int TW = three_wire_pkg::TMR_W;
	localparam int CW = three_wire_pkg::CNT_W;

	typedef enum logic [2:0] {
		S_IDLE,
		S_LOW,
		S_HIGH,
		S_HOLD,
		S_GAP
	} tx_state_t;

	tx_state_t     state_q;
	logic [TW-1:0] tmr_q;
	logic [CW-1:0] left_q;
	logic [W-1:0]  shift_q;
	logic          en_n_q;
	logic          clk_q;
	logic          data_q;

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	// The word is right-justified; it is moved up so its MSB leaves first.
	wire [CW-1:0] nbits = (cmd_len == three_wire_pkg::LEN_24) ? three_wire_pkg::LEN24_BITS :
	                      (cmd_len == three_wire_pkg::LEN_16) ? three_wire_pkg::LEN16_BITS :
	                      three_wire_pkg::LEN8_BITS;
	wire [CW-1:0] shamt  = CW'(W) - nbits;
	wire [W-1:0]  loaded = cmd_word << shamt;
	wire          take   = cmd_valid && cmd_ready_q;
	wire          tmr_0  = tmr_q == '0;

	assign link.en_n    = en_n_q;
	assign link.bus_clk = clk_q;
	assign link.sdata   = data_q;

	// ------------------------------------------------------------
	// Frame sequencer and clock divider
	// ------------------------------------------------------------
	// Enable stays low from the first bit to the last; data changes while
	// the clock is low and holds for a full half period before each rise.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q     <= S_IDLE;
			tmr_q       <= '0;
			left_q      <= '0;
			shift_q     <= '0;
			en_n_q      <= 1'b1;
			clk_q       <= 1'b0;
			data_q      <= 1'b0;
			cmd_ready_q <= 1'b0;
			cmd_done_q  <= 1'b0;
		end else begin
			cmd_done_q <= 1'b0;
			tmr_q      <= tmr_0 ? tmr_q : tmr_q - TW'(1);
			unique case (state_q)
				S_IDLE: begin
					cmd_ready_q <= 1'b1;
					if (take) begin
						cmd_ready_q <= 1'b0;
						en_n_q      <= 1'b0;
						shift_q     <= loaded << 1;
						data_q      <= loaded[W-1];
						left_q      <= nbits;
						tmr_q       <= TW'(LOW_CYC - 1);
						state_q     <= S_LOW;
					end
				end
				S_LOW: begin
					if (tmr_0) begin
						clk_q   <= 1'b1;
						tmr_q   <= TW'(HALF_CYC - 1);
						state_q <= S_HIGH;
					end
				end
				S_HIGH: begin
					if (tmr_0) begin
						clk_q  <= 1'b0;
						left_q <= left_q - three_wire_pkg::CNT_ONE;
						if (left_q == three_wire_pkg::CNT_ONE) begin
							tmr_q   <= TW'(EN_HOLD_CYC - 1);
							state_q <= S_HOLD;
						end else begin
							data_q  <= shift_q[W-1];
							shift_q <= shift_q << 1;
							tmr_q   <= TW'(HALF_CYC - 1);
							state_q <= S_LOW;
						end
					end
				end
				S_HOLD: begin
					if (tmr_0) begin
						en_n_q  <= 1'b1;
						data_q  <= 1'b0;
						tmr_q   <= TW'(GAP_CYC - 1);
						state_q <= S_GAP;
					end
				end
				S_GAP: begin
					if (tmr_0) begin
						cmd_done_q  <= 1'b1;
						cmd_ready_q <= 1'b1;
						state_q     <= S_IDLE;
					end
				end
			endcase
		end
	end
endmodule : three_wire_tx

// ---- tb/three_wire_asserts.sv ----
// Checker for the link wires and the device write strobes.
`timescale 1ns/1ps
module three_wire_asserts #(
	parameter int HALF_CYC = 4
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic en_n,
	input wire logic bus_clk,
	input wire logic sdata,
	input wire logic wr_stb_q,
	input wire logic drop_stb_q
);
	// ------------------------------------------------------------
	// Helper counters
	// ------------------------------------------------------------
	logic [7:0] hi_q;
	logic [5:0] bits_q;
	logic       clk_q;

	// Counts clock high cycles and clock rises inside a frame.
	always_ff @(posedge ref_clk) begin
		clk_q  <= bus_clk;
		hi_q   <= bus_clk ? hi_q + 8'h01 : 8'h00;
		bits_q <= en_n ? 6'h00 : bits_q + {5'h00, bus_clk & ~clk_q};
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	a_clk_still_idle: assert property (en_n |-> !bus_clk)
		else $error("Link clock high outside a frame.");
	a_first_rise: assert property ($fell(en_n) |-> !bus_clk ##[1:8] bus_clk)
		else $error("No clock rise after the frame start.");
	a_data_held_high: assert property (bus_clk |-> $stable(sdata))
		else $error("Data moved while the clock was high.");
	a_clk_high_time: assert property ($fell(bus_clk) |-> hi_q == 8'(HALF_CYC))
		else $error("Clock high time is wrong.");
	a_enable_hold: assert property ($rose(en_n) |-> $past(bus_clk, 2) == 1'b0)
		else $error("Enable rose too soon after the last bit.");
	a_frame_bit_count: assert property ($rose(en_n) |-> bits_q inside {6'h08, 6'h10, 6'h18})
		else $error("Frame length is not 8, 16 or 24.");
	a_commit_after_end: assert property ($rose(en_n) |-> ##[2:7] wr_stb_q)
		else $error("No write after the frame ended.");
	a_strobe_one_cycle: assert property (wr_stb_q |=> !wr_stb_q)
		else $error("Write strobe longer than one cycle.");
	a_strobe_not_in_frame: assert property (wr_stb_q |-> en_n)
		else $error("Write strobe during a frame.");
	a_no_drop_good: assert property (!drop_stb_q)
		else $error("Whole frame was dropped.");

	c_len8: cover property ($rose(en_n) && bits_q == 6'h08);
	c_len16: cover property ($rose(en_n) && bits_q == 6'h10);
	c_len24: cover property ($rose(en_n) && bits_q == 6'h18);
endmodule : three_wire_asserts

// ---- tb/tb.sv ----
// Bench: host and device ends face each other; a second device is fed by hand.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
	$display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb;
	typedef struct packed {
		three_wire_pkg::frame_len_t len;
		logic [1:0]                 addr;
		logic [23:0]                val;
	} note_t;

	logic                       ref_clk   = 1'b0;
	logic                       rst_n     = 1'b0;
	logic                       cmd_valid = 1'b0;
	three_wire_pkg::frame_len_t cmd_len   = three_wire_pkg::LEN_8;
	logic [23:0]                cmd_word  = 24'h000000;
	logic                       cmd_ready_q, cmd_done_q, wr_stb_q, drop_stb_q;
	logic                       wr_stb_b, drop_stb_b;
	logic [3:0][7:0]            cfg8_q, cfg8_b;
	logic [3:0][15:0]           cfg16_q;
	logic [3:0][23:0]           cfg24_q;
	logic [3:0]                 if_gain_q;
	three_wire_pkg::frame_len_t wr_len_q;
	logic [1:0]                 wr_addr_q;
	note_t                      q[$];
	note_t                      nt;
	int                         errors       = 0;
	int                         total_checks = 0;
	int                         done_cnt     = 0;
	int                         sent         = 0;
	int                         lens[10]     = '{7, 8, 9, 12, 16, 17, 23, 24, 25, 33};

	three_wire_if link();
	three_wire_if link_b();

	// Clock of the command side.
	always #5 ref_clk = ~ref_clk;

	// ------------------------------------------------------------
	// Instances
	// ------------------------------------------------------------
	three_wire_tx #(.HALF_CYC(4), .LOW_CYC(4), .EN_HOLD_CYC(2), .GAP_CYC(10)) u_three_wire_tx (
		.ref_clk(ref_clk), .rst_n(rst_n), .link(link.host), .cmd_valid(cmd_valid),
		.cmd_len(cmd_len), .cmd_word(cmd_word), .cmd_ready_q(cmd_ready_q),
		.cmd_done_q(cmd_done_q));
	three_wire_rx u_three_wire_rx (
		.ref_clk(ref_clk), .rst_n(rst_n), .link(link.dev), .cfg8_q(cfg8_q), .cfg16_q(cfg16_q),
		.cfg24_q(cfg24_q), .if_gain_q(if_gain_q), .wr_stb_q(wr_stb_q), .wr_len_q(wr_len_q),
		.wr_addr_q(wr_addr_q), .drop_stb_q(drop_stb_q));
	three_wire_rx u_three_wire_rx_b (
		.ref_clk(ref_clk), .rst_n(rst_n), .link(link_b.dev), .cfg8_q(cfg8_b), .cfg16_q(),
		.cfg24_q(), .if_gain_q(), .wr_stb_q(wr_stb_b), .wr_len_q(), .wr_addr_q(),
		.drop_stb_q(drop_stb_b));
	three_wire_asserts #(.HALF_CYC(4)) u_three_wire_asserts (
		.ref_clk(ref_clk), .rst_n(rst_n), .en_n(link.en_n), .bus_clk(link.bus_clk),
		.sdata(link.sdata), .wr_stb_q(wr_stb_q), .drop_stb_q(drop_stb_q));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	// Prints the counts and the verdict, then ends the run.
	task automatic complete_run();
		$display("Checks %0d, errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run

	// Reports a wait that ran out and closes the run.
	task automatic stall();
		errors++;
		$display("BAD t=%0t got=%0h exp=%0h", $time, 0, 1);
		complete_run();
	endtask : stall

	// Offers one command, keeps valid high, and notes the expected write.
	task automatic send(input three_wire_pkg::frame_len_t len, input logic [1:0] a);
		int          k;
		logic [23:0] w;
		note_t       n;
		w = 24'($urandom);
		w[7:6] = a;
		n.len = len;
		n.addr = a;
		n.val = w & (len == three_wire_pkg::LEN_8 ? 24'h0000FF :
		             len == three_wire_pkg::LEN_16 ? 24'h00FFFF : 24'hFFFFFF);
		cmd_len = len;
		cmd_word = w;
		cmd_valid = 1'b1;
		q.push_back(n);
		sent++;
		for (k = 0; k < 400 && cmd_ready_q !== 1'b1; k++) begin
			@(posedge ref_clk);
			#1;
		end
		if (k == 400) stall();
		@(posedge ref_clk);
		#1;
	endtask : send

	// Sends n bits MSB first on the hand-driven link and checks drop or write.
	task automatic raw(input int n, input logic [39:0] w);
		int k;
		link_b.en_n = 1'b0;
		#6;
		for (int i = n - 1; i >= 0; i--) begin
			link_b.sdata = w[i];
			#6 link_b.bus_clk = 1'b1;
			#6 link_b.bus_clk = 1'b0;
		end
		#12 link_b.en_n = 1'b1;
		link_b.sdata = ~link_b.sdata;
		for (k = 0; k < 20 && wr_stb_b !== 1'b1 && drop_stb_b !== 1'b1; k++) begin
			@(posedge ref_clk);
			#1;
		end
		if (k == 20) stall();
		`CHK(drop_stb_b, !(n inside {8, 16, 24}))
		`CHK(wr_stb_b, n inside {8, 16, 24})
		repeat (8) @(posedge ref_clk);
		#1;
	endtask : raw

	// ------------------------------------------------------------
	// Result watcher
	// ------------------------------------------------------------
	// Takes the oldest note when a write strobe appears and compares it.
	always @(posedge ref_clk) begin
		#1;
		if (cmd_done_q === 1'b1) done_cnt++;
		if (wr_stb_q === 1'b1 && q.size() == 0) `CHK(q.size() != 0, 1'b1)
		if (wr_stb_q === 1'b1 && q.size() != 0) begin
			nt = q.pop_front();
			`CHK(wr_len_q, nt.len)
			`CHK(wr_addr_q, nt.addr)
			if (nt.len == three_wire_pkg::LEN_8) `CHK(cfg8_q[nt.addr], nt.val[7:0])
			if (nt.len == three_wire_pkg::LEN_16) `CHK(cfg16_q[nt.addr], nt.val[15:0])
			if (nt.len == three_wire_pkg::LEN_24) `CHK(cfg24_q[nt.addr], nt.val)
			if (nt.len == three_wire_pkg::LEN_16 && nt.addr == 2'h0) `CHK(if_gain_q, nt.val[9:6])
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	// Resets, sends every length and address, then feeds odd frames by hand.
	initial begin
		link_b.en_n = 1'b1;
		link_b.bus_clk = 1'b0;
		link_b.sdata = 1'b0;
		void'($urandom(32'hAB6D));
		repeat (3) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		`CHK(if_gain_q, three_wire_pkg::IF_GAIN_RESET)
		for (int i = 0; i < 24; i++) send(three_wire_pkg::frame_len_t'(i % 3), 2'(i / 3));
		cmd_valid = 1'b0;
		for (int k = 0; k < 400 && q.size() != 0; k++) @(posedge ref_clk);
		if (q.size() != 0) stall();
		repeat (12) @(posedge ref_clk);
		#1;
		`CHK(q.size() == 0, 1'b1)
		`CHK(done_cnt, sent)
		repeat (3) begin
			#6 link_b.bus_clk = 1'b1;
			#6 link_b.bus_clk = 1'b0;
		end
		raw(8, 40'h00000000A5);
		`CHK(cfg8_b[2], 8'hA5)
		foreach (lens[i]) raw(lens[i], 40'({$urandom, $urandom}));
		complete_run();
	end
endmodule : tb
